// ---- dv/serial_ctrl_model.sv ----
// serial controller model driving the three-wire programming port
// assumes: bench clk_sys at 25 ns; serial clock period 200 ns
`timescale 1ns/1ps
module serial_ctrl_model (
   input wire logic clk_sys,
   output pll_synth_pkg::serial_pins_t pins
);
   initial begin
      pins = '0;
   end
   // ======================================
   // word, msb first, select bits last
   task automatic send(input logic [23:0] w, input int n, input bit en);
      pins.enable = en;
      repeat (4) @(negedge clk_sys);
      for (int i = n - 1; i >= 0; i--) begin
         pins.data = w[i];
         repeat (4) @(negedge clk_sys);
         pins.sclk = 1'b1;
         repeat (4) @(negedge clk_sys);
         pins.sclk = 1'b0;
         if (i == 0) begin
            pins.data = ~w[i]; // data turns after the last bit
         end
      end
      pins.enable = 1'b0;
      repeat (8) @(negedge clk_sys);
   endtask
endmodule

// ---- dv/tb_top.sv ----
// testbench for the synthesiser control block
// assumes: serial_ctrl_model drives the port; ticks made here
`timescale 1ns/1ps
module tb_top;
   logic clk_sys = 0, rst = 1, rfTick = 0, refTick = 0, lockDetected = 0, bank = 1, standbyPin = 0;
   pll_synth_pkg::serial_pins_t pins;
   logic fbOut, refOut, pol, lockSink, stbyAct;
   logic [1:0] gain;
   logic [1:0] refPhase = 2'h0;
   int errors = 0, cmp_count = 0, cyc = 0, n;
   // ======================================
   // clock, ticks, timeout
   always #12.5 clk_sys = ~clk_sys;
   always @(negedge clk_sys) begin
      rfTick <= ~rfTick;
      refPhase <= (refPhase == 2'h2) ? 2'h0 : refPhase + 2'h1;
      refTick <= (refPhase == 2'h0);
      cyc <= cyc + 1;
   end
   always @(posedge clk_sys) begin
      if (cyc == 60000) begin
         errors++;
         give_verdict();
      end
   end
   pll_synth_ctrl u_dut (.clk_sys(clk_sys), .rst(rst), .clkEn(1'b1), .serialPins(pins),
      .word_bank_select_pin(bank), .standbyPin(standbyPin), .rfTick(rfTick), .refTick(refTick),
      .lockDetected(lockDetected), .feedback_divider_pulse_out(fbOut), .referencePulseOut(refOut),
      .pumpGain(gain), .pumpPolarity(pol), .lockSinkEnable(lockSink), .standbyActive(stbyAct));
   serial_ctrl_model u_model (.clk_sys(clk_sys), .pins(pins));
   // ======================================
   // helpers
   function automatic logic [23:0] word(logic [1:0] c, logic p, logic [1:0] g, logic [14:0] m, logic [3:0] a);
      return {p, g, m, a, c[0], c[1]};
   endfunction
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   // ticks between pulses on one pin, after two settling periods
   task automatic measure(input bit onRef, input bit useRef, output int cnt);
      int guard;
      for (int k = 0; k < 3; k++) begin
         guard = 0;
         cnt = 0;
         do begin
            @(posedge clk_sys);
            #1;
            cnt += useRef ? refTick : rfTick;
            guard++;
         end while ((onRef ? refOut : fbOut) !== 1'b1 && guard < 10000);
      end
      @(negedge clk_sys);
   endtask
   task automatic give_verdict();
      $display("errors %0d comparisons %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // ======================================
   // tests
   initial begin
      repeat (16) @(negedge clk_sys);
      rst = 0;
      repeat (2) @(negedge clk_sys);
      check("gain", gain, 0);
      check("pol", pol, 0);
      check("standby", stbyAct, 0);
      lockDetected = 1;
      repeat (3) @(negedge clk_sys);
      check("lockSink", lockSink, 1);
      u_model.send(word(pll_synth_pkg::DEST_WORD1, 0, 2'h2, 15'd20, 4'd3), 24, 1);
      measure(0, 0, n);
      check("ratioWide", n, 323);
      check("gain", gain, 2);
      u_model.send({8'h00, 1'b0, 13'd5, 2'b11}, 24, 1);
      measure(0, 0, n);
      check("ratioNarrow", n, 163);
      measure(1, 1, n);
      check("refRatio", n, 5);
      u_model.send(word(pll_synth_pkg::DEST_WORD2, 1, 2'h3, 15'd10, 4'd1), 24, 1);
      measure(0, 0, n);
      check("ratioHeld", n, 163);
      bank = 0;
      wait (pol === 1'b1);
      measure(1, 0, n);
      check("ratioWord2", n, 81);
      check("pol", pol, 1);
      check("gain", gain, 3);
      measure(0, 1, n);
      check("refSwapped", n, 5);
      u_model.send(word(pll_synth_pkg::DEST_FINE, 0, 2'h0, 15'd0, 4'd5), 6, 1);
      measure(1, 0, n);
      check("ratioFine", n, 85);
      check("gain", gain, 3);
      u_model.send(24'hFFFFFF, 2, 0);
      u_model.send(24'h000000, 0, 1);
      measure(1, 0, n);
      check("ratioStray", n, 85);
      standbyPin = 1;
      repeat (8) @(negedge clk_sys);
      check("standby", stbyAct, 1);
      check("lockSink", lockSink, 0);
      u_model.send(word(pll_synth_pkg::DEST_WORD2, 1, 2'h1, 15'd10, 4'd1), 24, 1);
      n = 0;
      repeat (400) begin
         @(negedge clk_sys);
         n += refOut;
         n += fbOut;
      end
      check("stbyPulses", n, 0);
      standbyPin = 0;
      measure(1, 0, n);
      check("ratioAfter", n, 81);
      check("gain", gain, 1);
      give_verdict();
   end
endmodule

// ---- rtl/pll_synth_ctrl.sv ----
// control block of a pll synthesiser: serial port, word buffers, dividers
// assumes: rf and reference edges arrive as one-cycle enables on clk_sys
`timescale 1ns/1ps
module pll_synth_ctrl (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic clkEn,
   input wire pll_synth_pkg::serial_pins_t serialPins,
   input wire logic word_bank_select_pin,
   input wire logic standbyPin,
   input wire logic rfTick,
   input wire logic refTick,
   input wire logic lockDetected,
   output logic feedback_divider_pulse_out,
   output logic referencePulseOut,
   output logic [pll_synth_pkg::GAIN_W-1:0] pumpGain,
   output logic pumpPolarity,
   output logic lockSinkEnable,
   output logic standbyActive
);
   // ==========================================
   // pin synchronisers
   logic [pll_synth_pkg::SYNC_W-1:0] syncData, syncClk, syncEn, syncBank, syncStby;
   logic sclkLevel, enLevel, dataLevel, bankLevel, stbyLevel;
   logic sclkRise, enFall;

   function automatic logic agreed(input logic [2:0] s, input logic prev);
      agreed = (s[1] == s[2]) ? s[1] : prev;
   endfunction

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         syncData <= '0;
         syncClk <= '0;
         syncEn <= '0;
         syncBank <= '0;
         syncStby <= '0;
      end else if (clkEn) begin
         syncData <= {syncData[1:0], serialPins.data};
         syncClk <= {syncClk[1:0], serialPins.sclk};
         syncEn <= {syncEn[1:0], serialPins.enable};
         syncBank <= {syncBank[1:0], word_bank_select_pin};
         syncStby <= {syncStby[1:0], standbyPin};
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sclkLevel <= 1'b0;
         enLevel <= 1'b0;
         dataLevel <= 1'b0;
         bankLevel <= 1'b0;
         stbyLevel <= 1'b0;
      end else if (clkEn) begin
         sclkLevel <= agreed(syncClk, sclkLevel);
         enLevel <= agreed(syncEn, enLevel);
         dataLevel <= agreed(syncData, dataLevel);
         bankLevel <= agreed(syncBank, bankLevel);
         stbyLevel <= agreed(syncStby, stbyLevel);
      end
   end

   assign sclkRise = clkEn && !sclkLevel && agreed(syncClk, sclkLevel);
   assign enFall = clkEn && enLevel && !agreed(syncEn, enLevel);

   // ==========================================
   // shift register
   logic [pll_synth_pkg::SHIFT_W-1:0] shiftReg;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         shiftReg <= '0;
      end else if (sclkRise && enLevel) begin
         shiftReg <= {shiftReg[pll_synth_pkg::SHIFT_W-2:0], dataLevel};
      end
   end

   // ==========================================
   // word buffers
   pll_synth_pkg::div_word_t word1, word2;
   pll_synth_pkg::ref_word_t refWord;
   logic [pll_synth_pkg::FINE_W-1:0] pendingFine;
   logic finePending;
   logic [1:0] destSel;
   logic bankIsOne;
   logic cycleEnd;

   function automatic pll_synth_pkg::div_word_t unpack_word(input logic [pll_synth_pkg::SHIFT_W-1:0] s);
      unpack_word.fine = s[pll_synth_pkg::FINE_LSB +: pll_synth_pkg::FINE_W];
      unpack_word.coarse = s[pll_synth_pkg::COARSE_LSB +: pll_synth_pkg::COARSE_W];
      unpack_word.gain = s[pll_synth_pkg::GAIN_LSB +: pll_synth_pkg::GAIN_W];
      unpack_word.polarity = s[pll_synth_pkg::POL_BIT];
   endfunction

   function automatic pll_synth_pkg::div_word_t reset_word();
      reset_word.fine = pll_synth_pkg::FINE_RESET;
      reset_word.coarse = pll_synth_pkg::COARSE_RESET;
      reset_word.gain = '0;
      reset_word.polarity = 1'b0;
   endfunction

   assign destSel = {shiftReg[0], shiftReg[1]};
   assign bankIsOne = bankLevel;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         word1 <= reset_word();
         word2 <= reset_word();
      end else if (clkEn) begin
         if (enFall && destSel == pll_synth_pkg::DEST_WORD1) begin
            word1 <= unpack_word(shiftReg);
         end
         if (enFall && destSel == pll_synth_pkg::DEST_WORD2) begin
            word2 <= unpack_word(shiftReg);
         end
         if (finePending && cycleEnd) begin
            if (bankIsOne) begin
               word1.fine <= pendingFine;
            end else begin
               word2.fine <= pendingFine;
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pendingFine <= pll_synth_pkg::FINE_RESET;
         finePending <= 1'b0;
      end else if (clkEn) begin
         if (enFall && destSel == pll_synth_pkg::DEST_FINE) begin
            pendingFine <= shiftReg[pll_synth_pkg::FINE_LSB +: pll_synth_pkg::FINE_W];
            finePending <= 1'b1;
         end else if (cycleEnd) begin
            finePending <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         refWord <= '{wideModulus: 1'b1, count: pll_synth_pkg::REF_RESET};
      end else if (clkEn && enFall && destSel == pll_synth_pkg::DEST_REF) begin
         refWord.count <= shiftReg[pll_synth_pkg::REF_LSB +: pll_synth_pkg::REF_W];
         refWord.wideModulus <= shiftReg[pll_synth_pkg::MOD_BIT];
      end
   end

   // ==========================================
   // feedback divider
   pll_synth_pkg::div_word_t activeWord;
   logic [4:0] preCnt;
   logic [pll_synth_pkg::FINE_W-1:0] fineCnt;
   logic [pll_synth_pkg::COARSE_W-1:0] coarseCnt;
   logic modPlusOne, preWrap;
   logic activeWide;
   logic [4:0] modulus;

   assign modulus = activeWide ? pll_synth_pkg::MOD_HIGH : pll_synth_pkg::MOD_LOW;
   assign modPlusOne = fineCnt != activeWord.fine;
   assign preWrap = rfTick && !stbyLevel && (preCnt == (modPlusOne ? modulus : modulus - 5'h01));
   assign cycleEnd = preWrap && (coarseCnt == activeWord.coarse - 15'h0001);

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         preCnt <= '0;
         fineCnt <= '0;
         coarseCnt <= '0;
         activeWord <= reset_word();
         activeWide <= 1'b1;
      end else if (clkEn && !stbyLevel) begin
         if (rfTick) begin
            preCnt <= preWrap ? 5'h00 : preCnt + 5'h01;
         end
         if (cycleEnd) begin
            fineCnt <= '0;
            coarseCnt <= '0;
            activeWord <= bankIsOne ? word1 : word2;
            activeWide <= refWord.wideModulus;
         end else if (preWrap) begin
            coarseCnt <= coarseCnt + 15'h0001;
            if (modPlusOne) begin
               fineCnt <= fineCnt + 4'h1;
            end
         end
      end
   end

   // ==========================================
   // reference divider
   logic [pll_synth_pkg::REF_W-1:0] refCnt;
   logic refEnd;
   assign refEnd = refTick && (refCnt >= refWord.count - 13'h0001);

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         refCnt <= '0;
      end else if (clkEn && !stbyLevel && refTick) begin
         refCnt <= refEnd ? '0 : refCnt + 13'h0001;
      end
   end

   // ==========================================
   // outputs
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         feedback_divider_pulse_out <= 1'b0;
         referencePulseOut <= 1'b0;
         pumpGain <= '0;
         pumpPolarity <= 1'b0;
         lockSinkEnable <= 1'b0;
         standbyActive <= 1'b0;
      end else if (clkEn) begin
         feedback_divider_pulse_out <= activeWord.polarity ? (refEnd && !stbyLevel) : (cycleEnd && !stbyLevel);
         referencePulseOut <= activeWord.polarity ? (cycleEnd && !stbyLevel) : (refEnd && !stbyLevel);
         pumpGain <= activeWord.gain;
         pumpPolarity <= activeWord.polarity;
         lockSinkEnable <= lockDetected && !stbyLevel;
         standbyActive <= stbyLevel;
      end
   end

   // ==========================================
   // checks
   a_shift_hold: assert property (@(posedge clk_sys) disable iff (rst)
      !enLevel |=> shiftReg == $past(shiftReg)) else $error("shift changed with enable low");
   a_word1_load: assert property (@(posedge clk_sys) disable iff (rst)
      clkEn && enFall && destSel == pll_synth_pkg::DEST_WORD1
      |=> word1.coarse == $past(shiftReg[pll_synth_pkg::COARSE_LSB +: pll_synth_pkg::COARSE_W]))
      else $error("word one not loaded");
   a_active_stable: assert property (@(posedge clk_sys) disable iff (rst)
      !cycleEnd |=> activeWord == $past(activeWord)) else $error("active word changed mid cycle");
   a_bank_reload: assert property (@(posedge clk_sys) disable iff (rst)
      clkEn && !stbyLevel && cycleEnd && bankIsOne |=> activeWord.coarse == $past(word1.coarse))
      else $error("wrong bank reloaded");
   a_pulse_swap: assert property (@(posedge clk_sys) disable iff (rst)
      clkEn && !stbyLevel && cycleEnd && !refEnd && activeWord.polarity |=> referencePulseOut && !feedback_divider_pulse_out)
      else $error("polarity swap wrong");
   a_standby_quiet: assert property (@(posedge clk_sys) disable iff (rst)
      clkEn && stbyLevel |=> !feedback_divider_pulse_out && !referencePulseOut) else $error("pulse in standby");
   a_lock_sink: assert property (@(posedge clk_sys) disable iff (rst)
      clkEn && !lockDetected |=> !lockSinkEnable) else $error("lock sink without lock");
   a_fine_update: assert property (@(posedge clk_sys) disable iff (rst)
      clkEn && !stbyLevel && finePending && cycleEnd && bankIsOne && !enFall
      |=> word1.fine == $past(pendingFine) && word1.coarse == $past(word1.coarse))
      else $error("fine update wrong");
   a_fine_word2: assert property (@(posedge clk_sys) disable iff (rst)
      clkEn && !stbyLevel && finePending && cycleEnd && !bankIsOne && !enFall
      |=> word2.fine == $past(pendingFine) && word2.coarse == $past(word2.coarse))
      else $error("fine update of word two wrong");
   a_word2_load: assert property (@(posedge clk_sys) disable iff (rst)
      clkEn && enFall && destSel == pll_synth_pkg::DEST_WORD2
      |=> word2.coarse == $past(shiftReg[pll_synth_pkg::COARSE_LSB +: pll_synth_pkg::COARSE_W]))
      else $error("word two not loaded");
   a_ref_load: assert property (@(posedge clk_sys) disable iff (rst)
      clkEn && enFall && destSel == pll_synth_pkg::DEST_REF
      |=> refWord.count == $past(shiftReg[pll_synth_pkg::REF_LSB +: pll_synth_pkg::REF_W]))
      else $error("reference word not loaded");
   a_shift_in: assert property (@(posedge clk_sys) disable iff (rst)
      sclkRise && enLevel |=> shiftReg[0] == $past(dataLevel))
      else $error("serial bit not shifted in");
   a_bank_two: assert property (@(posedge clk_sys) disable iff (rst)
      clkEn && !stbyLevel && cycleEnd && !bankIsOne |=> activeWord.coarse == $past(word2.coarse))
      else $error("word two not reloaded");
   a_modulus_hold: assert property (@(posedge clk_sys) disable iff (rst)
      !cycleEnd |=> activeWide == $past(activeWide))
      else $error("modulus changed mid cycle");
   a_pre_range: assert property (@(posedge clk_sys) disable iff (rst)
      preCnt <= modulus)
      else $error("prescaler count past modulus");
   a_fb_pulse: assert property (@(posedge clk_sys) disable iff (rst)
      clkEn && !stbyLevel && cycleEnd && !activeWord.polarity |=> feedback_divider_pulse_out)
      else $error("feedback pulse missing");
   a_ref_pulse: assert property (@(posedge clk_sys) disable iff (rst)
      clkEn && !stbyLevel && refEnd && !activeWord.polarity |=> referencePulseOut)
      else $error("reference pulse missing");
   a_gain_follow: assert property (@(posedge clk_sys) disable iff (rst)
      clkEn |=> pumpGain == $past(activeWord.gain))
      else $error("pump gain not from active word");
   a_standby_flag: assert property (@(posedge clk_sys) disable iff (rst)
      clkEn |=> standbyActive == $past(stbyLevel))
      else $error("standby flag wrong");
endmodule

// ---- rtl/pll_synth_pkg.sv ----
// package: constants, field layouts and word types for the synthesiser control
// assumes: shared by the control block, the serial controller model and the testbench
package pll_synth_pkg;
   localparam int SHIFT_W = 24;
   localparam int WORD_W = 22;
   localparam int FINE_W = 4;
   localparam int COARSE_W = 15;
   localparam int REF_W = 13;
   localparam int GAIN_W = 2;
   localparam int SYNC_W = 3;
   // destination select codes, low bit sent first, then high bit
   localparam logic [1:0] DEST_WORD1 = 2'h0;
   localparam logic [1:0] DEST_WORD2 = 2'h2;
   localparam logic [1:0] DEST_FINE = 2'h1;
   localparam logic [1:0] DEST_REF = 2'h3;
   // divider word layout above the select bits: fine, coarse, gain, polarity
   localparam int FINE_LSB = 2;
   localparam int COARSE_LSB = 6;
   localparam int GAIN_LSB = 21;
   localparam int POL_BIT = 23;
   // reference word layout: count, then modulus select
   localparam int REF_LSB = 2;
   localparam int MOD_BIT = 15;
   localparam logic [COARSE_W-1:0] COARSE_RESET = 15'h0100;
   localparam logic [FINE_W-1:0] FINE_RESET = 4'h0;
   localparam logic [REF_W-1:0] REF_RESET = 13'h0001;
   localparam logic [4:0] MOD_LOW = 5'h08;
   localparam logic [4:0] MOD_HIGH = 5'h10;

   typedef struct packed {
      logic polarity;
      logic [GAIN_W-1:0] gain;
      logic [COARSE_W-1:0] coarse;
      logic [FINE_W-1:0] fine;
   } div_word_t;

   typedef struct packed {
      logic wideModulus;
      logic [REF_W-1:0] count;
   } ref_word_t;

   typedef struct packed {
      logic data;
      logic sclk;
      logic enable;
   } serial_pins_t;
endpackage
